// file: verilog/udw_host.sv
// Host sequencer that drives an up/down non-volatile wiper over its
// three-level select pin and its step/direction pin.
// Assumes an external driver turns the two select outputs into the
// low, normal high and high-voltage levels on the select pin.
//
// Functional notes
// - Plain store: both high, select low, select high before any step rise.
// - Host returns select high SETUP_CYC cycles after dropping step in plain store.
// - High-voltage increment: step high before high voltage; rises step up.
// - High-voltage decrement: step low before high voltage; rises step down.
// - Static step through high-voltage pulse stores and unfreezes.
// - Store and freeze: start high, high voltage, step low, then release.
// - Host ends the high-voltage store pulse as soon as allowed.
`timescale 1ns/100ps
module udw_host #(
  parameter int SETUP_CYC = udw_pkg::T_SETUP_CYC,
  parameter int STEP_CYC = udw_pkg::T_STEP_CYC,
  parameter int HOLD_CYC = udw_pkg::T_HOLD_CYC,
  parameter int WRITE_CYC = udw_pkg::T_WC_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire udw_pkg::udw_cmd_type cmd_op,
  input wire logic [udw_pkg::WIPER_W-1:0] cmd_steps,
  output logic cmd_ready,
  output logic sel_low_level,
  output logic sel_high_voltage_level,
  output logic step_level,
  output logic busy,
  output logic eeprom_write_busy,
  output logic setting_freeze
);

  // ==========================================================================
  // Command decoding
  // ==========================================================================
  function automatic logic f_is_hv(input udw_pkg::udw_cmd_type c);
    f_is_hv = (c == udw_pkg::UDW_HV_INC_UNFREEZE) ||
              (c == udw_pkg::UDW_HV_INC_FREEZE) ||
              (c == udw_pkg::UDW_HV_DEC_UNFREEZE) ||
              (c == udw_pkg::UDW_HV_DEC_FREEZE) ||
              (c == udw_pkg::UDW_HV_STORE_UNFREEZE) ||
              (c == udw_pkg::UDW_HV_STORE_FREEZE);
  endfunction : f_is_hv

  function automatic logic f_is_store(input udw_pkg::udw_cmd_type c);
    f_is_store = (c != udw_pkg::UDW_INC_NOSTORE) &&
                 (c != udw_pkg::UDW_DEC_NOSTORE);
  endfunction : f_is_store

  function automatic logic f_is_dec(input udw_pkg::udw_cmd_type c);
    f_is_dec = (c == udw_pkg::UDW_DEC_NOSTORE) ||
               (c == udw_pkg::UDW_DEC_STORE) ||
               (c == udw_pkg::UDW_HV_DEC_UNFREEZE) ||
               (c == udw_pkg::UDW_HV_DEC_FREEZE);
  endfunction : f_is_dec

  function automatic logic f_no_steps(input udw_pkg::udw_cmd_type c);
    f_no_steps = (c == udw_pkg::UDW_STORE) ||
                 (c == udw_pkg::UDW_HV_STORE_UNFREEZE) ||
                 (c == udw_pkg::UDW_HV_STORE_FREEZE);
  endfunction : f_no_steps

  // Step level held before select leaves the normal high level.
  function automatic logic f_first_level(input udw_pkg::udw_cmd_type c);
    f_first_level = !f_is_dec(c);
  endfunction : f_first_level

  // Step level held when select returns to the normal high level.
  function automatic logic f_final_level(input udw_pkg::udw_cmd_type c);
    case (c)
      udw_pkg::UDW_INC_NOSTORE: f_final_level = 1'b1;
      udw_pkg::UDW_INC_STORE: f_final_level = 1'b0;
      udw_pkg::UDW_DEC_NOSTORE: f_final_level = 1'b0;
      udw_pkg::UDW_DEC_STORE: f_final_level = 1'b1;
      udw_pkg::UDW_STORE: f_final_level = 1'b0;
      udw_pkg::UDW_HV_INC_UNFREEZE: f_final_level = 1'b1;
      udw_pkg::UDW_HV_INC_FREEZE: f_final_level = 1'b0;
      udw_pkg::UDW_HV_DEC_UNFREEZE: f_final_level = 1'b0;
      udw_pkg::UDW_HV_DEC_FREEZE: f_final_level = 1'b1;
      udw_pkg::UDW_HV_STORE_UNFREEZE: f_final_level = 1'b1;
      udw_pkg::UDW_HV_STORE_FREEZE: f_final_level = 1'b0;
      default: f_final_level = 1'b1;
    endcase
  endfunction : f_final_level

  function automatic logic [udw_pkg::TMR_W-1:0] f_cyc(input int n);
    f_cyc = (n < 1) ? 32'h00000001 : n[udw_pkg::TMR_W-1:0];
  endfunction : f_cyc

  // ==========================================================================
  // Wait timer
  // ==========================================================================
  udw_tmr_if tmr_bus ();

  udw_wait_timer u_tmr (
    .mclk (mclk),
    .rst_n (rst_n),
    .tmr_bus (tmr_bus.tmr)
  );

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  udw_pkg::udw_state_type state_ff;
  udw_pkg::udw_state_type nxt_state;
  udw_pkg::udw_cmd_type cmd_ff;
  udw_pkg::udw_cmd_type nxt_cmd;
  logic [udw_pkg::WIPER_W-1:0] steps_ff;
  logic [udw_pkg::WIPER_W-1:0] nxt_steps;
  logic sel_low_ff;
  logic nxt_sel_low;
  logic sel_hv_ff;
  logic nxt_sel_hv;
  logic step_ff;
  logic nxt_step;
  logic freeze_ff;
  logic nxt_freeze;
  logic tmr_start;
  logic [udw_pkg::TMR_W-1:0] tmr_load;

  assign tmr_bus.start = tmr_start;
  assign tmr_bus.load = tmr_load;

  assign cmd_ready = (state_ff == udw_pkg::UDW_S_IDLE);
  assign sel_low_level = sel_low_ff;
  assign sel_high_voltage_level = sel_hv_ff;
  assign step_level = step_ff;
  assign busy = (state_ff != udw_pkg::UDW_S_IDLE);
  assign eeprom_write_busy = (state_ff == udw_pkg::UDW_S_WRITE);
  assign setting_freeze = freeze_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_cmd = cmd_ff;
    nxt_steps = steps_ff;
    nxt_sel_low = sel_low_ff;
    nxt_sel_hv = sel_hv_ff;
    nxt_step = step_ff;
    nxt_freeze = freeze_ff;
    tmr_start = 1'b0;
    tmr_load = f_cyc(SETUP_CYC);
    case (state_ff)
      udw_pkg::UDW_S_IDLE: begin
        if (cmd_valid) begin
          nxt_cmd = cmd_op;
          nxt_steps = f_no_steps(cmd_op) ? udw_pkg::WIPER_MIN : cmd_steps;
          nxt_step = f_first_level(cmd_op);
          tmr_start = 1'b1;
          nxt_state = udw_pkg::UDW_S_SETUP;
        end
      end
      udw_pkg::UDW_S_SETUP: begin
        if (tmr_bus.done) begin
          nxt_sel_hv = f_is_hv(cmd_ff);
          nxt_sel_low = !f_is_hv(cmd_ff);
          tmr_start = 1'b1;
          nxt_state = udw_pkg::UDW_S_ENTER;
        end
      end
      udw_pkg::UDW_S_ENTER, udw_pkg::UDW_S_STEP_HI: begin
        if (tmr_bus.done) begin
          tmr_start = 1'b1;
          if (steps_ff != udw_pkg::WIPER_MIN) begin
            nxt_step = 1'b0;
            tmr_load = f_cyc(STEP_CYC);
            nxt_state = udw_pkg::UDW_S_STEP_LO;
          end else begin
            nxt_step = f_final_level(cmd_ff);
            nxt_state = udw_pkg::UDW_S_FINAL;
          end
        end
      end
      udw_pkg::UDW_S_STEP_LO: begin
        if (tmr_bus.done) begin
          nxt_step = 1'b1;
          nxt_steps = steps_ff - 6'h01;
          tmr_start = 1'b1;
          tmr_load = f_cyc(STEP_CYC);
          nxt_state = udw_pkg::UDW_S_STEP_HI;
        end
      end
      udw_pkg::UDW_S_FINAL: begin
        if (tmr_bus.done) begin
          nxt_sel_low = 1'b0;
          nxt_sel_hv = 1'b0;
          tmr_start = 1'b1;
          tmr_load = f_cyc(HOLD_CYC);
          nxt_state = udw_pkg::UDW_S_RELEASE;
          if (f_is_hv(cmd_ff) && f_is_store(cmd_ff)) begin
            nxt_freeze = (f_final_level(cmd_ff) == f_is_dec(cmd_ff));
          end
        end
      end
      udw_pkg::UDW_S_RELEASE: begin
        if (tmr_bus.done) begin
          if (f_is_store(cmd_ff)) begin
            tmr_start = 1'b1;
            tmr_load = f_cyc(WRITE_CYC);
            nxt_state = udw_pkg::UDW_S_WRITE;
          end else begin
            nxt_state = udw_pkg::UDW_S_IDLE;
          end
        end
      end
      udw_pkg::UDW_S_WRITE: begin
        if (tmr_bus.done) begin
          nxt_state = udw_pkg::UDW_S_IDLE;
        end
      end
      default: begin
        nxt_state = udw_pkg::UDW_S_IDLE;
        nxt_sel_low = 1'b0;
        nxt_sel_hv = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_ff <= udw_pkg::UDW_S_IDLE;
      cmd_ff <= udw_pkg::UDW_INC_NOSTORE;
      steps_ff <= 6'h00;
      sel_low_ff <= 1'b0;
      sel_hv_ff <= 1'b0;
      step_ff <= 1'b1;
      freeze_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cmd_ff <= nxt_cmd;
      steps_ff <= nxt_steps;
      sel_low_ff <= nxt_sel_low;
      sel_hv_ff <= nxt_sel_hv;
      step_ff <= nxt_step;
      freeze_ff <= nxt_freeze;
    end
  end

endmodule : udw_host

// file: include/udw_pkg.sv
// Constants and types shared by the up/down wiper host controller.
// Assumes a single 250 MHz clock domain on the controller side.
package udw_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_MHZ = 250;
  localparam int T_SETUP_NS = 1000;
  localparam int T_STEP_NS = 1000;
  localparam int T_HOLD_NS = 1000;
  localparam int T_WC_NS = 5000000;

  // Least times, rounded up to whole cycles.
  localparam int T_SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int T_STEP_CYC = (T_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int T_HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int T_WC_CYC = (T_WC_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================================
  // Wiper range and widths
  // ==========================================================================
  localparam int WIPER_W = 6;
  localparam logic [5:0] WIPER_MAX = 6'h3F;
  localparam logic [5:0] WIPER_MIN = 6'h00;
  localparam int TMR_W = 32;

  // ==========================================================================
  // Commands
  // ==========================================================================
  typedef enum logic [3:0] {
    UDW_INC_NOSTORE = 4'h0,
    UDW_INC_STORE = 4'h1,
    UDW_DEC_NOSTORE = 4'h2,
    UDW_DEC_STORE = 4'h3,
    UDW_STORE = 4'h4,
    UDW_HV_INC_UNFREEZE = 4'h5,
    UDW_HV_INC_FREEZE = 4'h6,
    UDW_HV_DEC_UNFREEZE = 4'h7,
    UDW_HV_DEC_FREEZE = 4'h8,
    UDW_HV_STORE_UNFREEZE = 4'h9,
    UDW_HV_STORE_FREEZE = 4'hA
  } udw_cmd_type;

  // ==========================================================================
  // Sequencer states
  // ==========================================================================
  typedef enum logic [7:0] {
    UDW_S_IDLE = 8'h01,
    UDW_S_SETUP = 8'h02,
    UDW_S_ENTER = 8'h04,
    UDW_S_STEP_LO = 8'h08,
    UDW_S_STEP_HI = 8'h10,
    UDW_S_FINAL = 8'h20,
    UDW_S_RELEASE = 8'h40,
    UDW_S_WRITE = 8'h80
  } udw_state_type;

endpackage : udw_pkg

// file: include/udw_tmr_if.sv
// Carrier between the host sequencer and its wait timer.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface udw_tmr_if;
  logic start;
  logic [udw_pkg::TMR_W-1:0] load;
  logic done;

  modport ctrl (output start, output load, input done);
  modport tmr (input start, input load, output done);
endinterface : udw_tmr_if

// file: verilog/udw_wait_timer.sv
// Down-counting wait timer: done pulses after load cycles.
// Assumes load is at least one and start is a one-cycle pulse.
`timescale 1ns/100ps
module udw_wait_timer (
  input wire logic mclk,
  input wire logic rst_n,
  udw_tmr_if.tmr tmr_bus
);

  // ==========================================================================
  // Counter
  // ==========================================================================
  logic [udw_pkg::TMR_W-1:0] cnt_ff;
  logic [udw_pkg::TMR_W-1:0] nxt_cnt;
  logic run_ff;
  logic nxt_run;

  assign tmr_bus.done = run_ff && (cnt_ff <= 32'h00000001);

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_run = run_ff;
    if (tmr_bus.start) begin
      nxt_cnt = tmr_bus.load;
      nxt_run = 1'b1;
    end else if (run_ff) begin
      if (tmr_bus.done) begin
        nxt_run = 1'b0;
      end else begin
        nxt_cnt = cnt_ff - 32'h00000001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_ff <= 32'h00000000;
      run_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
    end
  end

endmodule : udw_wait_timer

// file: test/udw_host_sva.sv
// Checker for the wiper host command port and pin sequencing.
// Assumes binding into udw_host; one clock, synchronous reset.
`timescale 1ns/100ps
module udw_host_sva #(
  parameter int SETUP_CYC = 1, parameter int STEP_CYC = 1,
  parameter int HOLD_CYC = 1, parameter int WRITE_CYC = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire udw_pkg::udw_cmd_type cmd_op,
  input wire logic cmd_ready,
  input wire logic sel_low_level,
  input wire logic sel_high_voltage_level,
  input wire logic step_level,
  input wire logic busy,
  input wire logic eeprom_write_busy,
  input wire logic setting_freeze
);
  // =======================================
  // Helper state and checks
  localparam int WR_MAX = 300;
  localparam logic [10:0] DIR_M = 11'h673;
  localparam logic [10:0] FIN_M = 11'h329;
  localparam logic [10:0] FRZ_M = 11'h540;
  localparam logic [10:0] STO_M = 11'h7FA;
  udw_pkg::udw_cmd_type op_ff, nxt_op;
  logic [31:0] wcnt_ff, nxt_wcnt;
  logic hv_op;
  always_comb begin
    nxt_op = (cmd_valid && cmd_ready) ? cmd_op : op_ff;
    nxt_wcnt = eeprom_write_busy ? wcnt_ff + 32'h1 : 32'h0;
    hv_op = op_ff >= udw_pkg::UDW_HV_INC_UNFREEZE;
  end
  always_ff @(posedge mclk) begin
    op_ff <= rst_n ? nxt_op : udw_pkg::UDW_STORE;
    wcnt_ff <= rst_n ? nxt_wcnt : 32'h0;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_take; cmd_valid && cmd_ready; endsequence
  sequence s_exit;
    $fell(sel_low_level) || $fell(sel_high_voltage_level);
  endsequence
  sequence s_store_exit;
    $fell(sel_high_voltage_level) || ($fell(sel_low_level) && STO_M[op_ff]);
  endsequence
  sel_exclusive_a: assert property (!(sel_low_level && sel_high_voltage_level))
    else $error("both select levels asserted");
  ready_busy_a: assert property (cmd_ready != busy)
    else $error("ready and busy agree");
  take_start_a: assert property (s_take |=> busy && !cmd_ready)
    else $error("command taken but not started");
  hv_entry_a: assert property ($rose(sel_high_voltage_level) |-> hv_op
    && step_level == DIR_M[op_ff] && $stable(step_level))
    else $error("bad high voltage entry");
  low_entry_a: assert property ($rose(sel_low_level) |-> !hv_op
    && step_level == DIR_M[op_ff])
    else $error("bad low level entry");
  exit_level_a: assert property (s_exit |-> step_level == FIN_M[op_ff])
    else $error("wrong step level at select release");
  freeze_update_a: assert property ($fell(sel_high_voltage_level) |->
    ##[0:1] setting_freeze == FRZ_M[op_ff])
    else $error("freeze record wrong after command");
  freeze_keep_a: assert property (!$stable(setting_freeze) |-> hv_op)
    else $error("freeze record changed by normal command");
  hv_static_a: assert property (sel_high_voltage_level && op_ff ==
    udw_pkg::UDW_HV_STORE_UNFREEZE |-> $stable(step_level))
    else $error("step moved during static store");
  store_no_rise_a: assert property (sel_low_level && op_ff ==
    udw_pkg::UDW_STORE |-> !$rose(step_level))
    else $error("step rose during plain store");
  write_start_a: assert property (s_store_exit |->
    ##[1:WR_MAX] eeprom_write_busy)
    else $error("write wait did not start");
  write_len_a: assert property ($fell(eeprom_write_busy) |->
    wcnt_ff inside {[WRITE_CYC:WRITE_CYC + 1]})
    else $error("write wait length wrong");
endmodule : udw_host_sva
bind udw_host udw_host_sva #(.SETUP_CYC(SETUP_CYC), .STEP_CYC(STEP_CYC),
  .HOLD_CYC(HOLD_CYC), .WRITE_CYC(WRITE_CYC)) u_udw_host_sva (
  .mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
  .cmd_ready(cmd_ready), .sel_low_level(sel_low_level),
  .sel_high_voltage_level(sel_high_voltage_level),
  .step_level(step_level), .busy(busy),
  .eeprom_write_busy(eeprom_write_busy), .setting_freeze(setting_freeze));

// file: test/udw_dev_model.sv
// Behavioural model of the up/down wiper device on the far side.
// Assumes select arrives as two level flags and step as a level.
`timescale 1ns/100ps
module udw_dev_model #(
  parameter int T_WC_NS = 60
) (
  input wire logic sel_low_level,
  input wire logic sel_high_voltage_level,
  input wire logic step_level,
  input wire logic pwr_cycle,
  output logic [5:0] wiper,
  output logic [5:0] stored,
  output logic frozen
);
  // =======================================
  // Command decode on pin edges
  logic hv_cls = 1'b0;
  logic up_dir = 1'b0;
  logic act = 1'b0;
  logic wr_busy = 1'b0;
  initial begin
    wiper = 6'h00;
    stored = 6'h00;
    frozen = 1'b0;
  end
  always @(posedge sel_low_level or posedge sel_high_voltage_level) begin
    act = !wr_busy && (sel_high_voltage_level || !frozen);
    hv_cls = sel_high_voltage_level;
    up_dir = step_level;
  end
  always @(posedge step_level) begin
    if (act && (sel_low_level || sel_high_voltage_level)) begin
      if (up_dir && wiper != 6'h3F) wiper = wiper + 6'h01;
      if (!up_dir && wiper != 6'h00) wiper = wiper - 6'h01;
    end
  end
  always @(negedge sel_low_level or negedge sel_high_voltage_level) begin
    if (act && (hv_cls || up_dir != step_level)) begin
      stored = wiper;
      if (hv_cls) frozen = up_dir != step_level;
      wr_busy = 1'b1;
      wr_busy <= #(T_WC_NS) 1'b0;
    end
    act = 1'b0;
  end
  always @(posedge pwr_cycle) wiper = stored;
endmodule : udw_dev_model

// file: test/udw_host_tb.sv
// Self-checking bench for udw_host driving the wiper device model.
// Assumes short timing parameters so the run stays brief.
`timescale 1ns/100ps
module udw_host_tb;
  // =======================================
  // Stimulus, model and checks
  localparam logic [10:0] DIR_M = 11'h673;
  localparam logic [10:0] FRZ_M = 11'h540;
  localparam logic [10:0] STO_M = 11'h7FA;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  udw_pkg::udw_cmd_type cmd_op = udw_pkg::UDW_STORE;
  logic [5:0] cmd_steps = 6'h00;
  logic pwr_cycle = 1'b0;
  logic cmd_ready, sel_lo, sel_hv, step, busy, wr_busy, frz, m_frz, exp_f;
  logic [5:0] m_wiper, m_stored, exp_w, exp_s;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  always #2 mclk = ~mclk;
  udw_host #(.SETUP_CYC(2), .STEP_CYC(2), .HOLD_CYC(2), .WRITE_CYC(20))
    u_udw_host (.mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_steps(cmd_steps), .cmd_ready(cmd_ready),
    .sel_low_level(sel_lo), .sel_high_voltage_level(sel_hv),
    .step_level(step), .busy(busy), .eeprom_write_busy(wr_busy),
    .setting_freeze(frz));
  udw_dev_model #(.T_WC_NS(60)) u_udw_dev_model (.sel_low_level(sel_lo),
    .sel_high_voltage_level(sel_hv), .step_level(step),
    .pwr_cycle(pwr_cycle), .wiper(m_wiper), .stored(m_stored),
    .frozen(m_frz));
  function automatic logic [5:0] sat(input logic [5:0] w, input logic up,
    input logic [5:0] n);
    int v;
    v = up ? int'(w) + int'(n) : int'(w) - int'(n);
    if (v > 63) v = 63;
    if (v < 0) v = 0;
    return 6'(v);
  endfunction : sat
  task automatic check(input logic [5:0] got, input logic [5:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("Checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic run_cmd(input int op, input logic [5:0] n);
    logic hv;
    logic saw_wr;
    logic [5:0] nn;
    hv = op >= 5;
    saw_wr = 1'b0;
    nn = (op == 4 || op >= 9) ? 6'h00 : n;
    // A zero-step decrement that must end high still makes one rising edge.
    if ((op == 3 || op == 8) && n == 6'h00) nn = 6'h01;
    cmd_op = udw_pkg::udw_cmd_type'(op[3:0]);
    cmd_steps = n;
    cmd_valid = 1'b1;
    @(posedge mclk);
    #1;
    while (cmd_ready !== 1'b1) begin
      saw_wr = saw_wr | wr_busy;
      cmd_op = udw_pkg::udw_cmd_type'(4'($urandom_range(10)));
      cmd_steps = 6'($urandom_range(63));
      @(posedge mclk);
      #1;
    end
    cmd_valid = 1'b0;
    if (hv || !exp_f) begin
      exp_w = sat(exp_w, DIR_M[op], nn);
      if (STO_M[op]) exp_s = exp_w;
      if (hv) exp_f = FRZ_M[op];
    end
    check(m_wiper, exp_w);
    check(m_stored, exp_s);
    check({4'h0, m_frz, frz}, {4'h0, exp_f, exp_f});
    check({5'h00, saw_wr}, {5'h00, STO_M[op]});
    @(posedge mclk);
    #1;
  endtask : run_cmd
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(32'hEE30));
    exp_w = 6'h00;
    exp_s = 6'h00;
    exp_f = 1'b0;
    repeat (10) @(posedge mclk);
    #1 rst_n = 1'b1;
    check({2'h0, cmd_ready, busy, frz, wr_busy}, 6'h08);
    @(posedge mclk);
    #1;
    run_cmd(5, 6'h3F);
    run_cmd(1, 6'h05);
    run_cmd(3, 6'h3F);
    run_cmd(2, 6'h03);
    for (int i = 0; i < 11; i++) run_cmd(i, 6'($urandom_range(63)));
    run_cmd(10, 6'h00);
    run_cmd(1, 6'h07);
    pwr_cycle = 1'b1;
    @(posedge mclk);
    #1 pwr_cycle = 1'b0;
    exp_w = exp_s;
    check(m_wiper, exp_w);
    check({5'h00, m_frz}, {5'h00, exp_f});
    run_cmd(9, 6'h00);
    repeat (40) run_cmd($urandom_range(10), 6'($urandom_range(63)));
    end_of_test();
  end
endmodule : udw_host_tb
